// >>> hw/rpfc_ctrl.sv
// reset mode sequencer, reset pin, power-fail monitor control and registers
// How it works
// - in reset the core halts and every io pin returns to its default state
// - leaving reset from any source starts fetch at address 8000h
// - reset sources: power-on or power-fail, pin, watchdog timeout, software reset
// - supply below warning raises power-fail interrupt; below operating level enters reset
// - after supply passes reset level, hold 8192 oscillator cycles before running
// - interval select 00 always on; 01,10,11 give 2^10, 2^11, 2^12 ring cycles
// - duty cycling only between power-on and reset thresholds in power-fail reset
// - interval select cleared only by power-on reset
// - leaving power-on or power-fail reset sets the power-on flag; software clears it
// - monitor always on in run; stop may switch it off only with regulator off
// - stop-mode monitor disable resets to zero
// - monitor off in stop: no warning, no reset-level; power-on reset still works
// - stop exit re-enables monitor; warning sets flag, reset level enters reset
// - power-fail interrupt gated only by its own enable, not the global one
// - in stop with clock halted a low reset pin forces reset at once
// - stay in reset while pin low; leave within four clocks after it rises
// - for non-pin resets drive the reset pin low throughout reset
// - a pin that cannot be pulled low leaves internal reset unaffected
// - watchdog reset holds four clocks and sets a flag only software clears
`timescale 1ns/1ps
module rpfc_ctrl #(
  parameter int STAB_CYC = rpfc_pkg::OSC_STAB_CYC
) (
  input wire logic mclk,
  input wire logic nrst,
  input rpfc_pkg::rpfc_bus_s bus,
  output logic [15:0] rdata,
  input rpfc_pkg::rpfc_mon_s mon,
  input wire logic ring_tick,
  input wire logic stop_mode,
  input wire logic wdog_timeout,
  input wire logic sw_reset,
  input wire logic rst_pin_i,
  output logic rst_pin_o,
  output logic rst_pin_oe,
  output logic cpu_reset,
  output logic io_default,
  output logic fetch_start,
  output logic [15:0] fetch_addr,
  output logic monitor_enable,
  output logic pf_irq_req
);
  import rpfc_pkg::*;

  // reset release through two flops; the first is read only by the second
  logic rst_meta_r;
  logic rst_n;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  rpfc_state_e state_r;
  rpfc_state_e state_nxt;
  rpfc_pwr_s pwr_r;
  rpfc_pwr_s pwr_nxt;
  logic wd_flag_r;
  logic por_flag_r;
  logic stop_d_r;
  logic [1:0] pin_lo_r;
  logic [1:0] pin_lo_nxt;
  logic [15:0] rdata_r;
  logic fetch_start_r;
  logic [15:0] fetch_addr_r;

  // state decoding
  logic in_reset_w;
  logic drive_pin_w;
  assign in_reset_w = (state_r == ST_PIN) || (state_r == ST_TIMED) ||
                      (state_r == ST_PWR) || (state_r == ST_STAB);
  assign drive_pin_w = (state_r == ST_TIMED) || (state_r == ST_PWR) ||
                       (state_r == ST_STAB);

  // monitor power: stop may turn it off only with the regulator off
  logic stop_off_w;
  logic duty_on_w;
  logic duty_sample_w;
  logic duty_active_w;
  assign stop_off_w = stop_mode && pwr_r.smd && !pwr_r.sre;
  assign monitor_enable = !stop_off_w && duty_on_w;
  assign duty_active_w = (state_r == ST_PWR) && !mon.por_low;

  rpfc_duty u_duty (
    .mclk(mclk),
    .rst_n(rst_n),
    .active(duty_active_w),
    .sel(pwr_r.sel),
    .ring_tick(ring_tick),
    .mon_on(duty_on_w),
    .sample(duty_sample_w)
  );

  // comparator results only count while the monitor is powered
  logic pf_detect_w;
  logic warn_detect_w;
  logic stop_exit_w;
  assign pf_detect_w = monitor_enable && mon.rst_low;
  assign warn_detect_w = monitor_enable && mon.warn_low &&
                         (state_r == ST_RUN || state_r == ST_CHECK);
  assign stop_exit_w = stop_d_r && !stop_mode;

  // pin filter: four consecutive low clocks while nobody drives it
  logic pin_trip_w;
  assign pin_lo_nxt = (state_r != ST_RUN || rst_pin_i) ? 2'h0 :
                      (pin_lo_r == 2'(PIN_FILTER_CYC - 1)) ? pin_lo_r : pin_lo_r + 2'h1;
  assign pin_trip_w = (state_r == ST_RUN) && !rst_pin_i &&
                      (pin_lo_r == 2'(PIN_FILTER_CYC - 1));

  // hold timer: watchdog/software hold and clock stabilisation
  logic tmr_load_w;
  logic [TMR_W-1:0] tmr_val_w;
  logic [TMR_W-1:0] tmr_cnt_w;
  logic tmr_done_w;
  assign tmr_load_w = (state_nxt != state_r) &&
                      (state_nxt == ST_TIMED || state_nxt == ST_STAB);
  assign tmr_val_w = (state_nxt == ST_STAB) ? TMR_W'(STAB_CYC - 1) :
                     TMR_W'(WDOG_HOLD_CYC - 1);

  rpfc_timer u_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .load(tmr_load_w),
    .load_val(tmr_val_w),
    .cnt(tmr_cnt_w),
    .done(tmr_done_w)
  );

  // sequencer; power-on beats every other source
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_RUN: begin
        if (mon.por_low || pf_detect_w) begin
          state_nxt = ST_PWR;
        end else if (wdog_timeout || sw_reset) begin
          state_nxt = ST_TIMED;
        end else if (pin_trip_w || (stop_mode && !rst_pin_i)) begin
          // a low pin in stop latches reset so the restart still goes through the vector
          state_nxt = ST_PIN;
        end else if (stop_exit_w) begin
          state_nxt = ST_CHECK;
        end
      end
      ST_CHECK: begin
        state_nxt = (mon.por_low || pf_detect_w) ? ST_PWR : ST_RUN;
      end
      ST_PIN: begin
        if (mon.por_low) begin
          state_nxt = ST_PWR;
        end else if (rst_pin_i) begin
          state_nxt = ST_RUN;
        end
      end
      ST_TIMED: begin
        if (mon.por_low) begin
          state_nxt = ST_PWR;
        end else if (tmr_done_w) begin
          state_nxt = ST_RUN;
        end
      end
      ST_PWR: begin
        // the pin is ours here, so its level is ignored
        if (duty_sample_w && !mon.rst_low) begin
          state_nxt = ST_STAB;
        end
      end
      ST_STAB: begin
        if (mon.por_low || pf_detect_w) begin
          state_nxt = ST_PWR;
        end else if (tmr_done_w) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_PWR;
      end
    endcase
  end

  // events that touch the registers
  logic rst_enter_w;
  logic por_enter_w;
  logic reset_exit_w;
  logic pwr_wr_w;
  logic wdc_wr_w;
  assign rst_enter_w = !in_reset_w && (state_nxt != ST_RUN) && (state_nxt != ST_CHECK);
  assign por_enter_w = mon.por_low && (state_nxt == ST_PWR);
  assign reset_exit_w = in_reset_w && (state_nxt == ST_RUN);
  // no register writes land while the core is held
  assign pwr_wr_w = bus.wr && (bus.addr == OFS_PWR_CTRL) && !cpu_reset;
  assign wdc_wr_w = bus.wr && (bus.addr == OFS_WDOG_CTRL) && !cpu_reset;

  // power control next value; hardware set of the flag wins over a clear
  always_comb begin
    pwr_nxt = pwr_r;
    if (pwr_wr_w) begin
      pwr_nxt.powerfail_interrupt_enable = bus.wdata[PC_POWERFAIL_INTERRUPT_ENABLE_BIT];
      pwr_nxt.pfi = bus.wdata[PC_PFI_BIT];
      pwr_nxt.smd = bus.wdata[PC_SMD_BIT];
      pwr_nxt.sre = bus.wdata[PC_SRE_BIT];
      pwr_nxt.sel = bus.wdata[PC_SEL_LSB +: 2];
    end
    if (rst_enter_w) begin
      pwr_nxt.powerfail_interrupt_enable = 1'b0;
      pwr_nxt.pfi = 1'b0;
      pwr_nxt.smd = 1'b0;
      pwr_nxt.sre = 1'b0;
    end
    if (por_enter_w) begin
      pwr_nxt.sel = SEL_RESET;
    end
    if (warn_detect_w) begin
      pwr_nxt.pfi = 1'b1;
    end
  end

  // sticky reset-cause flags, cleared by writing zero
  logic wd_flag_nxt;
  logic por_flag_nxt;
  logic por_exit_w;
  assign por_exit_w = (state_r == ST_STAB) && reset_exit_w;
  assign wd_flag_nxt = (wd_flag_r && !(wdc_wr_w && !bus.wdata[WC_WDRF_BIT])) ||
                       (state_r == ST_RUN && state_nxt == ST_TIMED && wdog_timeout);
  assign por_flag_nxt = (por_flag_r && !(wdc_wr_w && !bus.wdata[WC_POR_BIT])) ||
                        por_exit_w;

  // read mux; unmapped indexes read zero
  logic [15:0] pwr_rd_w;
  logic [15:0] wdc_rd_w;
  assign pwr_rd_w = {9'h000, pwr_r.sel, pwr_r.sre, pwr_r.smd, pwr_r.pfi, pwr_r.powerfail_interrupt_enable, 1'b0};
  assign wdc_rd_w = {13'h0000, por_flag_r, 1'b0, wd_flag_r};

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_PWR;
      pwr_r <= '0;
      wd_flag_r <= 1'b0;
      por_flag_r <= 1'b0;
      stop_d_r <= 1'b0;
      pin_lo_r <= 2'h0;
    end else begin
      state_r <= state_nxt;
      pwr_r <= pwr_nxt;
      wd_flag_r <= wd_flag_nxt;
      por_flag_r <= por_flag_nxt;
      stop_d_r <= stop_mode;
      pin_lo_r <= pin_lo_nxt;
    end
  end

  // read data and restart fetch request, one cycle after their cause
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 16'h0000;
      fetch_start_r <= 1'b0;
      fetch_addr_r <= 16'h0000;
    end else begin
      rdata_r <= !bus.rd ? 16'h0000 : (bus.addr == OFS_PWR_CTRL) ? pwr_rd_w :
                 (bus.addr == OFS_WDOG_CTRL) ? wdc_rd_w : 16'h0000;
      fetch_start_r <= reset_exit_w;
      fetch_addr_r <= reset_exit_w ? RESET_VECTOR : fetch_addr_r;
    end
  end

  // outputs; the stop-mode pin path has no flop since the clock may be dead
  assign cpu_reset = in_reset_w || (state_r == ST_CHECK) ||
                     (stop_mode && !rst_pin_i) || !rst_n;
  assign io_default = cpu_reset;
  assign rst_pin_o = 1'b0;
  assign rst_pin_oe = drive_pin_w;
  assign pf_irq_req = pwr_r.pfi && pwr_r.powerfail_interrupt_enable;
  assign rdata = rdata_r;
  assign fetch_start = fetch_start_r;
  assign fetch_addr = fetch_addr_r;

  // checks
  property p_fetch_vector;
    @(posedge mclk) disable iff (!rst_n)
      reset_exit_w |=> fetch_start && fetch_addr == 16'h8000;
  endproperty
  a_fetch_vector: assert property (p_fetch_vector) else $error("bad restart fetch");

  property p_wdog_hold;
    @(posedge mclk) disable iff (!rst_n)
      (state_r == ST_RUN && wdog_timeout && !mon.por_low && !pf_detect_w)
      |=> (state_r == ST_TIMED && cpu_reset)[*4] ##1 state_r != ST_TIMED;
  endproperty
  a_wdog_hold: assert property (p_wdog_hold) else $error("watchdog hold not four");

  property p_pin_release;
    @(posedge mclk) disable iff (!rst_n)
      (state_r == ST_PIN && rst_pin_i && !mon.por_low) |-> ##[1:4] state_r == ST_RUN;
  endproperty
  a_pin_release: assert property (p_pin_release) else $error("slow pin release");

  property p_pin_drive;
    @(posedge mclk) disable iff (!rst_n)
      (state_r inside {ST_TIMED, ST_PWR, ST_STAB}) |-> rst_pin_oe && !rst_pin_o && cpu_reset;
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("pin not driven");

  property p_irq_local;
    @(posedge mclk) disable iff (!rst_n)
      ($rose(pwr_r.pfi) && pwr_r.powerfail_interrupt_enable) |-> pf_irq_req;
  endproperty
  a_irq_local: assert property (p_irq_local) else $error("irq not raised");

  property p_sel_hold;
    @(posedge mclk) disable iff (!rst_n)
      (!pwr_wr_w && !por_enter_w) |=> $stable(pwr_r.sel);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("select changed");

  property p_por_flag;
    @(posedge mclk) disable iff (!rst_n)
      (state_r == ST_STAB && state_nxt == ST_RUN) |=> por_flag_r && state_r == ST_RUN;
  endproperty
  a_por_flag: assert property (p_por_flag) else $error("power-on flag missing");

  property p_mon_run;
    @(posedge mclk) disable iff (!rst_n)
      (state_r == ST_RUN && !stop_mode) |-> monitor_enable;
  endproperty
  a_mon_run: assert property (p_mon_run) else $error("monitor off in run");

  property p_stab_load;
    @(posedge mclk) disable iff (!rst_n)
      (state_r == ST_PWR && state_nxt == ST_STAB) |=> tmr_cnt_w == TMR_W'(STAB_CYC - 1);
  endproperty
  a_stab_load: assert property (p_stab_load) else $error("bad stabilise count");

  property p_stop_off;
    @(posedge mclk) disable iff (!rst_n)
      (stop_mode && pwr_r.smd && !pwr_r.sre) |-> !monitor_enable && !warn_detect_w;
  endproperty
  a_stop_off: assert property (p_stop_off) else $error("monitor on in stop");

  c_wdog: cover property (@(posedge mclk) disable iff (!rst_n)
    state_r == ST_TIMED ##1 state_r == ST_RUN);
  c_pin: cover property (@(posedge mclk) disable iff (!rst_n)
    state_r == ST_PIN ##1 state_r == ST_RUN);
  c_stop_check: cover property (@(posedge mclk) disable iff (!rst_n)
    state_r == ST_CHECK ##1 state_r == ST_PWR);
  c_stab: cover property (@(posedge mclk) disable iff (!rst_n)
    state_r == ST_STAB ##1 state_r == ST_RUN);
endmodule : rpfc_ctrl

// >>> hw/rpfc_pkg.sv
// shared constants and types of the reset and power-fail controller
package rpfc_pkg;
  // register index on the plain register port
  localparam logic [3:0] OFS_PWR_CTRL = 4'h0;
  localparam logic [3:0] OFS_WDOG_CTRL = 4'h1;
  // power_control_reg field positions
  localparam int PC_POWERFAIL_INTERRUPT_ENABLE_BIT = 1;
  localparam int PC_PFI_BIT = 2;
  localparam int PC_SMD_BIT = 3;
  localparam int PC_SRE_BIT = 4;
  localparam int PC_SEL_LSB = 5;
  // watchdog_control_reg field positions
  localparam int WC_WDRF_BIT = 0;
  localparam int WC_POR_BIT = 2;
  // values after reset and the always-on select code
  localparam logic [1:0] SEL_RESET = 2'h0;
  localparam logic [1:0] SEL_ALWAYS_ON = 2'h0;
  localparam logic [15:0] RESET_VECTOR = 16'h8000;
  // counts of cycles, the interval base exponent and counter widths
  localparam int PIN_FILTER_CYC = 4;
  localparam int WDOG_HOLD_CYC = 4;
  localparam int OSC_STAB_CYC = 8192;
  localparam int CHECK_ON_CYC = 3;
  localparam int CHECK_BASE_LOG2 = 9;
  localparam int TMR_W = 14;
  localparam int DUTY_W = 12;

  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_PIN = 3'b001,
    ST_TIMED = 3'b010,
    ST_PWR = 3'b011,
    ST_STAB = 3'b100,
    ST_CHECK = 3'b101
  } rpfc_state_e;

  typedef struct packed {
    logic [1:0] sel;
    logic sre;
    logic smd;
    logic pfi;
    logic powerfail_interrupt_enable;
  } rpfc_pwr_s;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } rpfc_bus_s;

  typedef struct packed {
    logic por_low;
    logic rst_low;
    logic warn_low;
  } rpfc_mon_s;
endpackage : rpfc_pkg

// >>> hw/rpfc_timer.sv
// loadable down counter for reset hold and clock stabilisation delays
`timescale 1ns/1ps
module rpfc_timer (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [rpfc_pkg::TMR_W-1:0] load_val,
  output logic [rpfc_pkg::TMR_W-1:0] cnt,
  output logic done
);
  import rpfc_pkg::*;

  logic [TMR_W-1:0] cnt_r;
  logic [TMR_W-1:0] cnt_nxt;

  // load wins; otherwise count down to zero and rest there
  assign cnt_nxt = load ? load_val : (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
  assign cnt = cnt_r;
  assign done = (cnt_r == '0);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule : rpfc_timer

// >>> hw/rpfc_duty.sv
// duty-cycle gate of the reset-level monitor, paced by the ring oscillator tick
`timescale 1ns/1ps
module rpfc_duty (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic active,
  input wire logic [1:0] sel,
  input wire logic ring_tick,
  output logic mon_on,
  output logic sample
);
  import rpfc_pkg::*;

  logic [DUTY_W-1:0] cnt_r;
  logic [DUTY_W-1:0] last_w;
  logic always_on_w;
  logic [DUTY_W-1:0] cnt_nxt;

  // interval length 2^(9+sel) ticks; 00 means no interval
  assign always_on_w = (sel == SEL_ALWAYS_ON);
  assign last_w = DUTY_W'((1 << (CHECK_BASE_LOG2 + int'(sel))) - 1);
  assign cnt_nxt = (!active) ? '0 : (!ring_tick) ? cnt_r : (cnt_r == last_w) ? '0 : cnt_r + 1'b1;
  // powered for the first three ticks, compare read on the third
  assign mon_on = !active || always_on_w || (cnt_r < DUTY_W'(CHECK_ON_CYC));
  assign sample = active && (always_on_w ||
                  (ring_tick && cnt_r == DUTY_W'(CHECK_ON_CYC - 1)));

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule : rpfc_duty

// >>> verification/rpfc_far_model.sv
// far-side model: external reset circuit on the pin and the analog supply monitor
`timescale 1ns/1ps
module rpfc_far_model #(
  parameter int RING_DIV = 4
) (
  input wire logic mclk,
  input wire logic pin_oe,
  input wire logic ext_low,
  input wire logic rc_hold,
  input wire logic [1:0] supply,
  input wire logic mon_pwr,
  output logic pin_lvl,
  output rpfc_pkg::rpfc_mon_s mon,
  output logic ring_tick
);
  import rpfc_pkg::*;
  int div = 0;
  logic warn_last = 1'b0;
  logic rst_last = 1'b0;
  // pulled-up pin; an rc network may keep the device from pulling it low
  assign pin_lvl = !((pin_oe && !rc_hold) || ext_low);
  // comparators report only while powered, so remember what they last said
  always_ff @(posedge mclk) begin
    if (mon_pwr) begin
      warn_last <= supply != 2'h0;
      rst_last <= supply >= 2'h2;
    end
  end
  // an unpowered comparator shows the inverse of its last answer, not a held value
  assign mon.por_low = supply == 2'h3;
  assign mon.rst_low = mon_pwr ? supply >= 2'h2 : !rst_last;
  assign mon.warn_low = mon_pwr ? supply != 2'h0 : !warn_last;
  // ring oscillator stand-in: one tick every RING_DIV system clocks
  always_ff @(posedge mclk) begin
    div <= (div == RING_DIV - 1) ? 0 : div + 1;
  end
  assign ring_tick = div == 0;
endmodule : rpfc_far_model

// >>> verification/tb_reset_and_power_fail_control.sv
// self-checking bench of the reset and power-fail controller
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module tb_reset_and_power_fail_control;
  import rpfc_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  rpfc_bus_s bus = '0;
  rpfc_mon_s mon;
  logic [15:0] rdata, fetch_addr, d;
  logic ring_tick, pin_lvl, pin_oe, cpu_reset, io_default, fetch_start, monitor_enable;
  logic pf_irq_req, oe, powerfail_interrupt_enable;
  logic stop_mode = 1'b0;
  logic wdog_timeout = 1'b0;
  logic sw_reset = 1'b0;
  logic ext_low = 1'b0;
  logic rc_hold = 1'b0;
  logic [1:0] supply = 2'h0;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  int seed, n, k, hi;

  // 40 MHz system clock
  initial begin
    forever #12.5 mclk = !mclk;
  end

  rpfc_ctrl #(.STAB_CYC(16)) dut (.mclk(mclk), .nrst(nrst), .bus(bus), .rdata(rdata),
    .mon(mon), .ring_tick(ring_tick), .stop_mode(stop_mode), .wdog_timeout(wdog_timeout),
    .sw_reset(sw_reset), .rst_pin_i(pin_lvl), .rst_pin_o(), .rst_pin_oe(pin_oe),
    .cpu_reset(cpu_reset), .io_default(io_default), .fetch_start(fetch_start),
    .fetch_addr(fetch_addr), .monitor_enable(monitor_enable), .pf_irq_req(pf_irq_req));

  rpfc_far_model #(.RING_DIV(4)) far (.mclk(mclk), .pin_oe(pin_oe), .ext_low(ext_low),
    .rc_hold(rc_hold), .supply(supply), .mon_pwr(monitor_enable), .pin_lvl(pin_lvl),
    .mon(mon), .ring_tick(ring_tick));

  // expected power_control_reg word from its fields
  function automatic logic [15:0] pwr_word(logic [1:0] sel, logic sre, logic smd, logic pfi,
                                           logic powerfail_interrupt_enable_v);
    pwr_word = '0;
    pwr_word[PC_SEL_LSB +: 2] = sel;
    pwr_word[PC_SRE_BIT] = sre;
    pwr_word[PC_SMD_BIT] = smd;
    pwr_word[PC_PFI_BIT] = pfi;
    pwr_word[PC_POWERFAIL_INTERRUPT_ENABLE_BIT] = powerfail_interrupt_enable_v;
  endfunction : pwr_word

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge mclk);
    bus.addr <= a;
    bus.wdata <= v;
    bus.wr <= 1'b1;
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge mclk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1;
    v = rdata;
  endtask : rd

  // counts reset cycles; bounded so a stuck reset cannot hang the run
  task automatic hold_len(output int cnt, output logic oe_all);
    cnt = 0;
    oe_all = 1'b1;
    while (cpu_reset === 1'b1 && cnt < 20000) begin
      cnt++;
      oe_all &= pin_oe;
      @(posedge mclk);
      #1;
    end
  endtask : hold_len

  // called right after hold_len, while the one-cycle fetch pulse still stands
  task automatic fetch_ok();
    `CHK(fetch_start, 1'b1)
    `CHK(fetch_addr, RESET_VECTOR)
    `CHK(io_default, 1'b0)
  endtask : fetch_ok

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  // hang guard, sized well above the longest duty-cycled wait
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      test_done();
    end
  end

  initial begin
    seed = 9;
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    // power-on: held through stabilisation, pin driven low meanwhile
    `CHK(io_default, cpu_reset)
    hold_len(n, oe);
    `CHK(n >= 16, 1'b1)
    `CHK(oe, 1'b1)
    fetch_ok();
    rd(OFS_WDOG_CTRL, d);
    `CHK(d, 16'h1 << WC_POR_BIT)
    rd(OFS_PWR_CTRL, d);
    `CHK(d, 16'h0000)
    rd(4'hf, d);
    `CHK(d, 16'h0000)
    $display("test power_on done");

    // pin: a three-cycle glitch is ignored, a long low resets
    @(posedge mclk);
    ext_low <= 1'b1;
    repeat (3) @(posedge mclk);
    ext_low <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    `CHK(cpu_reset, 1'b0)
    k = 4 + ($random(seed) & 3);
    @(posedge mclk);
    ext_low <= 1'b1;
    repeat (k) @(posedge mclk);
    #1;
    `CHK(cpu_reset, 1'b1)
    @(posedge mclk);
    ext_low <= 1'b0;
    #1;
    hold_len(n, oe);
    `CHK(n <= 4, 1'b1)
    fetch_ok();
    $display("test pin_reset done");

    // watchdog then software reset, the latter with the pin held up externally
    for (int s = 0; s < 2; s++) begin
      @(posedge mclk);
      rc_hold <= (s == 1);
      wdog_timeout <= (s == 0);
      sw_reset <= (s == 1);
      @(posedge mclk);
      wdog_timeout <= 1'b0;
      sw_reset <= 1'b0;
      #1;
      hold_len(n, oe);
      `CHK(n, WDOG_HOLD_CYC)
      `CHK(oe, 1'b1)
      fetch_ok();
      rd(OFS_WDOG_CTRL, d);
      `CHK(d, (16'h1 << WC_POR_BIT) | ((s == 0) ? 16'h1 << WC_WDRF_BIT : 16'h0))
      wr(OFS_WDOG_CTRL, 16'h1 << WC_POR_BIT);
      rd(OFS_WDOG_CTRL, d);
      `CHK(d, 16'h1 << WC_POR_BIT)
    end
    rc_hold <= 1'b0;
    $display("test timed_resets done");

    // warning raises the request through its own enable alone
    powerfail_interrupt_enable = 1'($random(seed));
    wr(OFS_PWR_CTRL, pwr_word(2'h0, 1'b0, 1'b0, 1'b0, powerfail_interrupt_enable));
    @(posedge mclk);
    supply <= 2'h1;
    repeat (3) @(posedge mclk);
    rd(OFS_PWR_CTRL, d);
    `CHK(d, pwr_word(2'h0, 1'b0, 1'b0, 1'b1, powerfail_interrupt_enable))
    `CHK(pf_irq_req, powerfail_interrupt_enable)
    supply <= 2'h0;
    wr(OFS_PWR_CTRL, pwr_word(2'h0, 1'b0, 1'b0, 1'b0, 1'b1));
    #1;
    `CHK(pf_irq_req, 1'b0)
    $display("test warning done");

    // power fail with interval 2^10 ticks; select survives the reset
    wr(OFS_WDOG_CTRL, 16'h0000);
    wr(OFS_PWR_CTRL, pwr_word(2'h1, 1'b0, 1'b0, 1'b0, 1'b0));
    @(posedge mclk);
    supply <= 2'h2;
    repeat (2) @(posedge mclk);
    #1;
    `CHK(cpu_reset, 1'b1)
    `CHK(pin_oe, 1'b1)
    hi = 0;
    repeat (4096) begin
      @(posedge mclk);
      #1;
      hi += monitor_enable;
    end
    `CHK(hi >= 4 && hi <= 16, 1'b1)
    @(posedge mclk);
    supply <= 2'h0;
    #1;
    hold_len(n, oe);
    fetch_ok();
    rd(OFS_PWR_CTRL, d);
    // the warning seen on the reset entry edge wins over the entry clear
    `CHK(d, pwr_word(2'h1, 1'b0, 1'b0, 1'b1, 1'b0))
    rd(OFS_WDOG_CTRL, d);
    `CHK(d[WC_POR_BIT], 1'b1)
    `CHK(monitor_enable, 1'b1)
    $display("test power_fail done");

    // stop with regulator on keeps the monitor; warning raised in stop sets the flag
    wr(OFS_PWR_CTRL, pwr_word(2'h1, 1'b1, 1'b1, 1'b0, 1'b0));
    @(posedge mclk);
    stop_mode <= 1'b1;
    @(posedge mclk);
    #1;
    `CHK(monitor_enable, 1'b1)
    supply <= 2'h1;
    @(posedge mclk);
    stop_mode <= 1'b0;
    repeat (3) @(posedge mclk);
    rd(OFS_PWR_CTRL, d);
    `CHK(d[PC_PFI_BIT], 1'b1)
    supply <= 2'h0;
    wr(OFS_PWR_CTRL, 16'h0000);
    // pin low in stop resets at once, before any clock edge
    @(posedge mclk);
    stop_mode <= 1'b1;
    ext_low <= 1'b1;
    #1;
    `CHK(cpu_reset, 1'b1)
    @(posedge mclk);
    ext_low <= 1'b0;
    stop_mode <= 1'b0;
    #1;
    hold_len(n, oe);
    fetch_ok();
    // monitor off in stop: reset level ignored, power-on level still resets
    wr(OFS_PWR_CTRL, pwr_word(2'h1, 1'b0, 1'b1, 1'b0, 1'b0));
    @(posedge mclk);
    stop_mode <= 1'b1;
    supply <= 2'h2;
    repeat (8) @(posedge mclk);
    #1;
    `CHK(monitor_enable, 1'b0)
    `CHK(cpu_reset, 1'b0)
    supply <= 2'h3;
    repeat (3) @(posedge mclk);
    #1;
    `CHK(cpu_reset, 1'b1)
    stop_mode <= 1'b0;
    supply <= 2'h0;
    hold_len(n, oe);
    fetch_ok();
    rd(OFS_PWR_CTRL, d);
    `CHK(d, 16'h0000)
    $display("test stop_mode done");
    test_done();
  end
endmodule : tb_reset_and_power_fail_control
